/* bench/tb_timer2_capture_compare_regs.sv */
// Self-checking bench for the timer 2 block
`timescale 1ns/1ps
module tb_timer2_capture_compare_regs;
    import timer2_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, count_pin, reload_pin, timer_irq;
    logic [NUM_CH-1:0] capture_pins, compare_out, ch_irq;
    int                n_errors, checks_done;

    timer2_capture_compare_regs DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_pin(count_pin), .reload_pin(reload_pin),
        .capture_pins(capture_pins), .compare_out(compare_out),
        .timer_irq(timer_irq), .ch_irq(ch_irq));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, data};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        apb(1'b1, idx, data);
    endtask : wr
    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h0, exp});
    endtask : chk_reg
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge pclk);
            count_pin <= 1'b0;
            repeat (2) @(posedge pclk);
            count_pin <= 1'b1;
            repeat (2) @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : pulse_count
    task automatic pins(input logic [3:0] v);
        @(posedge pclk);
        capture_pins <= v;
        repeat (3) @(posedge pclk);
    endtask : pins
    ////////////////////////////////////////////////////////////
    task automatic test_regs();
        for (int i = 0; i < NUM_CH; i++) begin
            chk_reg(IDX_CH_LO[i], 8'h00);
            chk_reg(IDX_CH_HI[i], 8'h00);
            wr(IDX_CH_LO[i], 8'hA0 + 8'(i));
            wr(IDX_CH_HI[i], 8'h50 + 8'(i));
            chk_reg(IDX_CH_LO[i], 8'hA0 + 8'(i));
            chk_reg(IDX_CH_HI[i], 8'h50 + 8'(i));
        end
        chk_reg(IDX_CNT_LO, 8'h00);
        wr(IDX_CNT_LO, 8'h5A);
        wr(IDX_CNT_HI, 8'hA5);
        chk_reg(IDX_CNT_LO, 8'h5A);
        chk_reg(IDX_CNT_HI, 8'hA5);
        apb(1'b0, 8'h00, 8'h00);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_sources();
        for (int ps = 0; ps < 3; ps++) begin
            count_pin <= (ps < 2);
            wr(IDX_CNT_LO, 8'h00);
            wr(IDX_CNT_HI, 8'h00);
            wr(IDX_CTRL, (ps < 2) ? {ps[0], 7'h01} : 8'h03);
            repeat (ps == 1 ? 242 : 122) @(posedge pclk);
            wr(IDX_CTRL, 8'h00);
            repeat (30) @(posedge pclk);
            chk_reg(IDX_CNT_LO, (ps < 2) ? 8'h0A : 8'h00);
        end
        count_pin <= 1'b1;
        wr(IDX_CTRL, 8'h03);
        repeat (122) @(posedge pclk);
        wr(IDX_CTRL, 8'h02);
        chk_reg(IDX_CNT_LO, 8'h0A);
        pulse_count(5);
        chk_reg(IDX_CNT_LO, 8'h0F);
        $display("test_sources done");
    endtask : test_sources
    task automatic test_reload();
        logic [1:0] rl;
        wr(IDX_CH_LO[0], 8'h34);
        wr(IDX_CH_HI[0], 8'h12);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_CNT_HI, 8'hFF);
            wr(IDX_CNT_LO, 8'hFD);
            wr(IDX_CTRL, {3'h0, k[1:0], 3'h2});
            pulse_count(3);
            chk_reg(IDX_CNT_LO, k == 2 ? 8'h34 : 8'h00);
            chk_reg(IDX_CNT_HI, k == 2 ? 8'h12 : 8'h00);
            chk_reg(IDX_FLAGS, 8'h40);
            wr(IDX_FLAGS, 8'h00);
            chk_reg(IDX_FLAGS, 8'h00);
        end
        wr(IDX_IEN_LO, 8'hA0);
        wr(IDX_IEN_HI, 8'h80);
        for (int k = 0; k < 2; k++) begin
            rl = k ? 2'h3 : 2'h0;
            wr(IDX_CNT_LO, 8'h05);
            wr(IDX_CTRL, {3'h0, rl, 3'h0});
            @(posedge pclk);
            reload_pin <= 1'b0;
            repeat (3) @(posedge pclk);
            reload_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            check(32'(timer_irq), 32'(k));
            chk_reg(IDX_CNT_LO, k ? 8'h34 : 8'h05);
        end
        wr(IDX_IEN_HI, 8'h00);
        repeat (2) @(posedge pclk);
        check(32'(timer_irq), 32'h0);
        wr(IDX_FLAGS, 8'h00);
        $display("test_reload done");
    endtask : test_reload
    task automatic test_capture();
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CH_LO[3], 8'hEE);
        wr(IDX_CH_FUNC, 8'h15);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h42);
        pins(4'hF);
        chk_reg(IDX_CH_LO[1], 8'h42);
        chk_reg(IDX_CH_LO[3], 8'hEE);
        chk_reg(IDX_CH_LO[0], 8'h34);
        wr(IDX_CNT_LO, 8'h77);
        pins(4'h0);
        chk_reg(IDX_CH_LO[0], 8'h77);
        chk_reg(IDX_CH_LO[2], 8'h42);
        wr(IDX_CTRL, 8'h40);
        wr(IDX_CNT_LO, 8'h99);
        pins(4'h1);
        chk_reg(IDX_CH_LO[0], 8'h99);
        wr(IDX_CH_FUNC, 8'hFF);
        wr(IDX_CNT_HI, 8'h01);
        wr(IDX_CNT_LO, 8'h23);
        wr(IDX_CH_LO[2], 8'h5A);
        chk_reg(IDX_CH_LO[2], 8'h23);
        chk_reg(IDX_CH_HI[2], 8'h01);
        $display("test_capture done");
    endtask : test_capture
    task automatic test_compare();
        wr(IDX_CH_FUNC, 8'h0A);
        wr(IDX_CH_LO[0], 8'h03);
        wr(IDX_CH_HI[0], 8'h00);
        wr(IDX_CH_LO[1], 8'h02);
        wr(IDX_CH_HI[1], 8'h00);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h01);
        wr(IDX_CTRL, 8'h02);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_IEN_HI, 8'h0C);
        check(32'(compare_out[1:0]), 32'h3);
        pulse_count(2);
        check(32'(compare_out[1:0]), 32'h1);
        chk_reg(IDX_FLAGS, 8'h08);
        pulse_count(1);
        chk_reg(IDX_FLAGS, 8'h0C);
        check(32'(ch_irq[1:0]), 32'h3);
        wr(IDX_CTRL, 8'h42);
        wr(IDX_CNT_LO, 8'h02);
        wr(IDX_FLAGS, 8'h00);
        pulse_count(1);
        chk_reg(IDX_FLAGS, 8'h04);
        wr(IDX_NEXT_LVL, 8'h02);
        wr(IDX_CTRL, 8'h06);
        wr(IDX_CH_LO[1], 8'h05);
        pulse_count(1);
        check(32'(compare_out[1]), 32'h0);
        pulse_count(1);
        check(32'(compare_out[1]), 32'h1);
        wr(IDX_CH_FUNC, 8'h00);
        pulse_count(2);
        check(32'(compare_out[1]), 32'h1);
        wr(IDX_IEN_LO, 8'h20);
        $display("test_compare done");
    endtask : test_compare
    ////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        final_report();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {count_pin, reload_pin, capture_pins} = 6'h30;
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_sources();
        test_reload();
        test_capture();
        test_compare();
        final_report();
    end
endmodule : tb_timer2_capture_compare_regs

/* bench/timer2_capture_compare_regs_monitor.sv */
// Bus and interrupt checks for the timer 2 block
`timescale 1ns/1ps
module timer2_capture_compare_regs_monitor (
    input wire logic                           pclk,
    input wire logic                           presetn,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [timer2_pkg::ADDR_W-1:0]  paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           count_pin,
    input wire logic                           reload_pin,
    input wire logic [timer2_pkg::NUM_CH-1:0]  capture_pins,
    input wire logic [timer2_pkg::NUM_CH-1:0]  compare_out,
    input wire logic                           timer_irq,
    input wire logic [timer2_pkg::NUM_CH-1:0]  ch_irq
);
    import timer2_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_first_access;
        psel && penable && !pready;
    endsequence
    sequence s_wr_to(logic [7:0] idx);
        psel && penable && pready && pwrite && paddr == {2'h0, idx, 2'h0};
    endsequence
    ////////////////////////////////////////////////////////////
    AST_ONE_WAIT: assert property (s_setup ##1 s_first_access |=> pready)
        else $error("pready not one cycle after access start");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_READY_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_ALIGN: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_BYTE_DATA: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data wider than one byte");
    AST_GLOBAL_OFF: assert property (
        s_wr_to(IDX_IEN_LO) ##0 !pwdata[7] |=> ##1 !timer_irq && ch_irq == 4'h0)
        else $error("interrupt active with global enable off");
    AST_FUNC_OFF: assert property (
        s_wr_to(IDX_CH_FUNC) ##0 pwdata[7:0] == 8'h00
        |=> ##2 $stable(compare_out)[*2])
        else $error("compare output moved with channels disabled");
endmodule : timer2_capture_compare_regs_monitor

bind timer2_capture_compare_regs timer2_capture_compare_regs_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_pin(count_pin),
    .reload_pin(reload_pin), .capture_pins(capture_pins),
    .compare_out(compare_out), .timer_irq(timer_irq), .ch_irq(ch_irq));

/* hdl/timer2_capture_compare_regs.sv */
// Timer 2 counter with four capture/compare channels behind APB
//
// Notes on behaviour
// - Mode 01 counts pclk divided by 12, or by 24 with prescale set.
// - Count control: 00 stop, 10 count pin edges, 11 gated prescaled.
// - Gated mode holds while count pin low, counts while high.
// - Ch0 compare, edge select 0: flag when equality ends.
// - Ch0 compare, edge select 1: flag when equality begins.
// - Ch0 pin capture, edge select 0: capture on falling pin edge.
// - Ch0 pin capture, edge select 1: capture on rising pin edge.
// - Reload select 00 or 01: counter never reloaded.
// - Reload select 10: counter loads channel 0 on overflow.
// - Reload select 11: counter loads channel 0 on reload pin edge.
// - Method 0: compare pin follows the comparison directly.
// - Direct output low when channel below counter, else high.
// - Method 1: pin holds, takes preset level on a match.
// - Each channel has a 2-bit function; 00 disables it.
// - Function 01: capture counter on capture pin edge; rising for channels 1 to 3, channel 0 per edge select.
// - Function 10: channel compares against the counter.
// - Function 11: writing the low byte captures the counter.
// - Software capture stores the counter, written data dropped.
// - Counter readable and writable as two bytes, reset zero.
// - Channel values readable and writable as two bytes, reset zero.
// - Overflow flag set when the counter passes FFFF, also when reloaded; software read/write.
// - Overflow interrupt needs its enable and the global enable.
// - Reload interrupt only while its enable bit is set; here the reload flag is set only while the overflow enable is also set.
// - Channel compare interrupt enables at bits 2 to 5.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module timer2_capture_compare_regs (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [timer2_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         count_pin,
    input  wire logic                         reload_pin,
    input  wire logic [timer2_pkg::NUM_CH-1:0] capture_pins,
    output logic      [timer2_pkg::NUM_CH-1:0] compare_out,
    output logic                              timer_irq,
    output logic      [timer2_pkg::NUM_CH-1:0] ch_irq
);
    import timer2_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    timer_ctrl_s        ctrl_q;
    ien_lo_s            ien_lo_q;
    ien_hi_s            ien_hi_q;
    logic [7:0]         ch_func_q;
    logic [NUM_CH-1:0]  next_lvl_q;
    logic [15:0]        cnt_q;
    logic [15:0]        cnt_d;
    logic               ovf_flag_q;
    logic               rl_flag_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               timer_irq_q;
    logic [NUM_CH-1:0]  ch_irq_q;
    logic [NUM_CH-1:0]  cmp_flag;
    logic [NUM_CH-1:0]  cmp_pin;
    logic [15:0]        ch_val [NUM_CH];
    logic [7:0]         rd_ch  [NUM_CH];

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign timer_irq   = timer_irq_q;
    assign ch_irq      = ch_irq_q;
    assign compare_out = cmp_pin;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire [7:0] idx      = paddr[9:2];
    wire       in_range = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
    wire       acc      = psel & penable & pready_q;
    wire       wr       = acc & pwrite;
    wire [7:0] wbyte    = pwdata[7:0];

    wire hit_ien_lo = in_range && (idx == IDX_IEN_LO);
    wire hit_ien_hi = in_range && (idx == IDX_IEN_HI);
    wire hit_flags  = in_range && (idx == IDX_FLAGS);
    wire hit_func   = in_range && (idx == IDX_CH_FUNC);
    wire hit_ctrl   = in_range && (idx == IDX_CTRL);
    wire hit_cnt_lo = in_range && (idx == IDX_CNT_LO);
    wire hit_cnt_hi = in_range && (idx == IDX_CNT_HI);
    wire hit_next   = in_range && (idx == IDX_NEXT_LVL);

    logic [NUM_CH-1:0] hit_ch_lo;
    logic [NUM_CH-1:0] hit_ch_hi;

    wire hit_any = hit_ien_lo | hit_ien_hi | hit_flags | hit_func
                 | hit_ctrl | hit_cnt_lo | hit_cnt_hi | hit_next
                 | (|hit_ch_lo) | (|hit_ch_hi);

    wire [7:0] flags_byte = {rl_flag_q, ovf_flag_q, cmp_flag, 2'h0};

    wire [7:0] rd_regs = ({8{hit_ien_lo}} & ien_lo_q)
                       | ({8{hit_ien_hi}} & ien_hi_q)
                       | ({8{hit_flags}}  & flags_byte)
                       | ({8{hit_func}}   & ch_func_q)
                       | ({8{hit_ctrl}}   & ctrl_q)
                       | ({8{hit_cnt_lo}} & cnt_q[7:0])
                       | ({8{hit_cnt_hi}} & cnt_q[15:8])
                       | ({8{hit_next}}   & {4'h0, next_lvl_q});
    wire [7:0] rd_byte = rd_regs | rd_ch[0] | rd_ch[1] | rd_ch[2] | rd_ch[3];

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr_q <= ~hit_any;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= RESET_BYTE;
            ien_lo_q   <= RESET_BYTE;
            ien_hi_q   <= RESET_BYTE;
            ch_func_q  <= RESET_BYTE;
            next_lvl_q <= '0;
        end else begin
            if (wr && hit_ctrl)   ctrl_q     <= wbyte;
            if (wr && hit_ien_lo) ien_lo_q   <= wbyte;
            if (wr && hit_ien_hi) ien_hi_q   <= wbyte;
            if (wr && hit_func)   ch_func_q  <= wbyte;
            if (wr && hit_next)   next_lvl_q <= wbyte[NUM_CH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin edges and prescaler

    logic              pre_tick;
    logic              cnt_pin_fall;
    logic              rl_pin_fall;
    logic [NUM_CH-1:0] cap_rise;
    logic [NUM_CH-1:0] cap_fall;
    logic [1:0]        unused_rise;

    count_mode_e  cmode;
    reload_mode_e rmode;
    assign cmode = count_mode_e'(ctrl_q.count_control);
    assign rmode = reload_mode_e'(ctrl_q.reload_select);

    timer2_prescaler u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (cmode == CNT_CPU || cmode == CNT_GATED),
        .div24   (ctrl_q.prescale_select),
        .tick    (pre_tick)
    );

    timer2_pin_edge #(.W(NUM_CH + 2)) u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({capture_pins, reload_pin, count_pin}),
        .rise    ({cap_rise, unused_rise}),
        .fall    ({cap_fall, rl_pin_fall, cnt_pin_fall})
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter

    wire tick_cpu   = (cmode == CNT_CPU) & pre_tick;
    wire tick_pin   = (cmode == CNT_PIN) & cnt_pin_fall;
    wire tick_gated = (cmode == CNT_GATED) & pre_tick & count_pin;
    wire cnt_tick   = tick_cpu | tick_gated | tick_pin;
    wire overflow   = cnt_tick && (cnt_q == CNT_MAX);
    wire rl_by_ovf  = (rmode == RL_OVF) & overflow;
    wire rl_by_pin  = (rmode == RL_PIN) & rl_pin_fall;
    wire wr_cnt_lo  = wr & hit_cnt_lo;
    wire wr_cnt_hi  = wr & hit_cnt_hi;

    // Software byte writes win over counting and reload
    always_comb begin
        cnt_d = cnt_q;
        if (rl_by_ovf || rl_by_pin) begin
            cnt_d = ch_val[0];
        end else if (cnt_tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (wr_cnt_lo) cnt_d[7:0]  = wbyte;
        if (wr_cnt_hi) cnt_d[15:8] = wbyte;
    end

    // Hardware set wins over a software clear in the same cycle
    wire wr_flags = wr & hit_flags;
    wire rl_set   = rl_by_pin & ien_hi_q.reload_irq_enable
                  & ien_lo_q.overflow_irq_enable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q      <= 16'h0000;
            ovf_flag_q <= 1'b0;
            rl_flag_q  <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            ovf_flag_q <= overflow |
                          (wr_flags ? wbyte[FLAG_OVF] : ovf_flag_q);
            rl_flag_q  <= rl_set |
                          (wr_flags ? wbyte[FLAG_RELOAD] : rl_flag_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            logic [15:0] val_q;
            logic [15:0] val_d;
            logic        eq_q;
            logic        flag_q;
            logic        out_q;
            ch_func_e    fn;

            assign fn = ch_func_e'(ch_func_q[2*i +: 2]);
            assign hit_ch_lo[i] = in_range && (idx == IDX_CH_LO[i]);
            assign hit_ch_hi[i] = in_range && (idx == IDX_CH_HI[i]);

            wire wr_lo = wr & hit_ch_lo[i];
            wire wr_hi = wr & hit_ch_hi[i];
            wire cmp   = (fn == FN_COMPARE);
            wire eq    = (val_q == cnt_q);

            // Channel 0 edge choice; others use the rising edge
            wire pin_edge = (i == 0 && !ctrl_q.ch0_edge_select) ?
                            cap_fall[i] : cap_rise[i];
            wire cap_hw = (fn == FN_CAP_PIN) & pin_edge;
            wire cap_sw = (fn == FN_CAP_SW) & wr_lo;

            wire eq_begin = cmp & eq & ~eq_q;
            wire eq_end   = cmp & ~eq & eq_q;
            wire hit_set  = (i == 0 && !ctrl_q.ch0_edge_select) ?
                            eq_end : eq_begin;

            always_comb begin
                val_d = val_q;
                if (wr_hi) val_d[15:8] = wbyte;
                if (wr_lo) val_d[7:0]  = wbyte;
                if (cap_hw || cap_sw) val_d = cnt_q;
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    val_q  <= 16'h0000;
                    eq_q   <= 1'b0;
                    flag_q <= 1'b0;
                    out_q  <= 1'b0;
                end else begin
                    val_q  <= val_d;
                    eq_q   <= eq;
                    flag_q <= hit_set |
                              (wr_flags ? wbyte[FLAG_CMP_LSB + i] : flag_q);
                    if (cmp && !ctrl_q.compare_output_method) begin
                        out_q <= (val_q >= cnt_q);
                    end else if (cmp && eq_begin) begin
                        out_q <= next_lvl_q[i];
                    end
                end
            end

            assign ch_val[i]   = val_q;
            assign cmp_flag[i] = flag_q;
            assign cmp_pin[i]  = out_q;
            assign rd_ch[i]    = ({8{hit_ch_lo[i]}} & val_q[7:0])
                               | ({8{hit_ch_hi[i]}} & val_q[15:8]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request outputs

    wire ovf_req = ien_lo_q.global_irq_enable
                 & ien_lo_q.overflow_irq_enable & ovf_flag_q;
    wire rl_req  = ien_lo_q.global_irq_enable
                 & ien_hi_q.reload_irq_enable & rl_flag_q;
    wire [NUM_CH-1:0] ch_req = {NUM_CH{ien_lo_q.global_irq_enable}}
                             & ien_hi_q.ch_irq_enable & cmp_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_q <= 1'b0;
            ch_irq_q    <= '0;
        end else begin
            timer_irq_q <= ovf_req | rl_req;
            ch_irq_q    <= ch_req;
        end
    end

endmodule : timer2_capture_compare_regs

/* hdl/timer2_pin_edge.sv */
// Edge detector for pins already synchronous to pclk
`timescale 1ns/1ps
module timer2_pin_edge #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev_q;
    logic         armed_q;

    // No edge reported until one real sample is held
    assign rise = {W{armed_q}} & pin & ~prev_q;
    assign fall = {W{armed_q}} & ~pin & prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= pin;
            armed_q <= 1'b1;
        end
    end

endmodule : timer2_pin_edge

/* hdl/timer2_pkg.sv */
// Shared constants, field layouts and types for the timer 2 block
package timer2_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IEN_LO   = 8'hA8;
    localparam logic [7:0] IDX_IEN_HI   = 8'hB8;
    localparam logic [7:0] IDX_FLAGS    = 8'hC0;
    localparam logic [7:0] IDX_CH_FUNC  = 8'hC1;
    localparam logic [7:0] IDX_CTRL     = 8'hC8;
    localparam logic [7:0] IDX_CNT_LO   = 8'hCC;
    localparam logic [7:0] IDX_CNT_HI   = 8'hCD;
    localparam logic [7:0] IDX_NEXT_LVL = 8'hCE;
    // Low byte index per channel, channel 0 in the lowest slot
    localparam logic [3:0][7:0] IDX_CH_LO = {8'hC6, 8'hC4, 8'hC2, 8'hCA};
    localparam logic [3:0][7:0] IDX_CH_HI = {8'hC7, 8'hC5, 8'hC3, 8'hCB};

    localparam int         ADDR_W      = 12;
    localparam int         NUM_CH      = 4;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;

    // Prescaler division in pclk cycles
    localparam logic [4:0] PRE_DIV_12  = 5'h0C;
    localparam logic [4:0] PRE_DIV_24  = 5'h18;

    // Flag register bit positions
    localparam int FLAG_RELOAD  = 7;
    localparam int FLAG_OVF     = 6;
    localparam int FLAG_CMP_LSB = 2;

    typedef enum logic [1:0] {
        CNT_STOP  = 2'h0,
        CNT_CPU   = 2'h1,
        CNT_PIN   = 2'h2,
        CNT_GATED = 2'h3
    } count_mode_e;

    typedef enum logic [1:0] {
        RL_OFF0 = 2'h0,
        RL_OFF1 = 2'h1,
        RL_OVF  = 2'h2,
        RL_PIN  = 2'h3
    } reload_mode_e;

    typedef enum logic [1:0] {
        FN_OFF     = 2'h0,
        FN_CAP_PIN = 2'h1,
        FN_COMPARE = 2'h2,
        FN_CAP_SW  = 2'h3
    } ch_func_e;

    typedef struct packed {
        logic        prescale_select;
        logic        ch0_edge_select;
        logic        spare;
        logic [1:0]  reload_select;
        logic        compare_output_method;
        logic [1:0]  count_control;
    } timer_ctrl_s;

    typedef struct packed {
        logic        global_irq_enable;
        logic        other6;
        logic        overflow_irq_enable;
        logic [4:0]  other4_0;
    } ien_lo_s;

    typedef struct packed {
        logic        reload_irq_enable;
        logic        other6;
        logic [3:0]  ch_irq_enable;
        logic [1:0]  other1_0;
    } ien_hi_s;

endpackage : timer2_pkg

/* hdl/timer2_prescaler.sv */
// Prescaler giving a one-cycle tick every 12 or 24 pclk cycles
`timescale 1ns/1ps
module timer2_prescaler (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic div24,
    output logic      tick
);
    import timer2_pkg::*;

    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    wire  [4:0] last = (div24 ? PRE_DIV_24 : PRE_DIV_12) - 5'h01;
    wire        wrap = (cnt_q >= last);

    assign tick  = run & wrap;
    assign cnt_d = (!run || wrap) ? 5'h00 : cnt_q + 5'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : timer2_prescaler
